/* inc/mon_consts.vh */
// constants for the monitor serial debug port
`ifndef MON_CONSTS_VH
`define MON_CONSTS_VH

// serial timing, in bus clock cycles
`define BIT_CYC 256
`define HALF_BIT_CYC 128
`define TARGET_BAUD 9600
`define GAP_BITS 2
`define GAP_CYC (`GAP_BITS * `BIT_CYC)
`define CMD_DELAY_BITS 11
`define CMD_DELAY_CYC (`CMD_DELAY_BITS * `BIT_CYC)
`define FRAME_BITS 10

// command opcodes
`define OP_READ 8'h4a
`define OP_WRITE 8'h49
`define OP_INDEXED_READ_CMD 8'h1a
`define OP_INDEXED_WRITE_CMD 8'h19
`define OP_STACK_POINTER_READ_CMD 8'h0c
`define OP_RUN 8'h28

// security handling
`define SEC_BYTES 8
`define SEC_BLANK 8'hff
`define SEC_FLAG_ADDR 16'h0040
`define SEC_FLAG_BIT 6
`define FLASH_BASE 16'hc000
`define INVALID_DATA 8'had

// vector pages
`define VEC_PAGE_MON 8'hfe

// transmit queue
`define TXQ_WIDTH 9
`define TXQ_DEPTH 8
`define TXQ_AW 3

`endif

/* rtl/mon_fifo.v */
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/1ps
module mon_fifo #(
  parameter WIDTH = 9,
  parameter DEPTH = 8,
  parameter AW = 3
) (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_in_valid,
  output wire o_in_ready,
  input wire [WIDTH-1:0] i_in_data,
  output wire o_out_valid,
  input wire i_out_ready,
  output wire [WIDTH-1:0] o_out_data
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_ptr;
  reg [AW-1:0] rd_ptr;
  reg [AW:0] count;
  wire push;
  wire pop;

  // honest full and empty from the occupancy count
  assign o_in_ready = (count != DEPTH[AW:0]);
  assign o_out_valid = (count != {(AW+1){1'b0}});
  assign o_out_data = mem[rd_ptr];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  // storage write
  always @(posedge i_core_clk) begin
    if (push) begin
      mem[wr_ptr] <= i_in_data;
    end
  end

  // pointers and count
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_ptr <= {AW{1'b0}};
      rd_ptr <= {AW{1'b0}};
      count <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        count <= count + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        count <= count - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule

/* rtl/monitor_serial_port.v */
// monitor mode serial debug port: receiver, command engine, transmitter
`timescale 1ns/1ps
`include "mon_consts.vh"
module monitor_serial_port (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_por_n,
  input wire i_serial_pin,
  output reg o_serial_pin_out,
  output reg o_serial_pin_oe,
  input wire [63:0] i_sec_code,
  input wire i_mass_erase,
  input wire [15:0] i_stack_ptr,
  input wire [7:0] i_mem_rdata,
  output reg [15:0] o_mem_addr,
  output reg [7:0] o_mem_wdata,
  output reg o_mem_rd,
  output reg o_mem_wr,
  output reg o_stack_entry,
  output reg o_run,
  output reg o_flash_locked,
  output reg [7:0] o_vector_page
);
  // engine states, one-hot
  localparam S_START = 13'h0001;
  localparam S_SEC = 13'h0002;
  localparam S_SECCHK = 13'h0004;
  localparam S_FRD = 13'h0008;
  localparam S_FWR = 13'h0010;
  localparam S_BRK = 13'h0020;
  localparam S_IDLE = 13'h0040;
  localparam S_ARG = 13'h0080;
  localparam S_WAIT = 13'h0100;
  localparam S_EXEC = 13'h0200;
  localparam S_RWAIT = 13'h0400;
  localparam S_RDAT = 13'h0800;
  localparam S_SPLO = 13'h1000;

  // transmitter states, one-hot
  localparam T_IDLE = 3'h1;
  localparam T_GAP = 3'h2;
  localparam T_FRAME = 3'h4;

  // receiver states, one-hot
  localparam R_ARM = 3'h1;
  localparam R_IDLE = 3'h2;
  localparam R_BITS = 3'h4;

  // counter end values, cut to their counter widths where used
  localparam [31:0] HALF_LAST = `HALF_BIT_CYC - 1;
  localparam [31:0] BIT_LAST = `BIT_CYC - 1;
  localparam [31:0] GAP_LAST = `GAP_CYC - 1;
  localparam [31:0] WAIT_LAST = `CMD_DELAY_CYC - 1;
  localparam [31:0] FRAME_LAST = `FRAME_BITS - 1;
  localparam [31:0] SEC_LAST = `SEC_BYTES - 1;

  // byte of the stored code at a given position
  function [7:0] code_byte;
    input [63:0] code;
    input [2:0] idx;
    begin
      code_byte = code[{idx, 3'b000} +: 8];
    end
  endfunction

  // address falls in the protected flash range
  function in_flash;
    input [15:0] addr;
    begin
      in_flash = (addr >= `FLASH_BASE);
    end
  endfunction

  reg sync1;
  reg sync2;
  reg sync3;
  reg rx_line;
  reg [2:0] rx_state;
  reg [7:0] rx_cyc;
  reg [3:0] rx_bit;
  reg [8:0] rx_shift;
  reg rx_byte;
  reg rx_break;
  reg [7:0] rx_data;
  reg [2:0] tx_state;
  reg [9:0] tx_cyc;
  reg [3:0] tx_bit;
  reg [9:0] tx_shift;
  reg [12:0] state;
  reg [1:0] arg_cnt;
  reg [23:0] argv;
  reg [7:0] cmd;
  reg [15:0] idx;
  reg [2:0] sec_cnt;
  reg sec_ok;
  reg sec_pass;
  reg sec_bypass;
  reg [63:0] sec_code;
  reg [11:0] wait_cnt;
  reg push_valid;
  reg [8:0] push_data;
  wire push_ready;
  wire txq_valid;
  wire [8:0] txq_data;
  wire tx_take;
  wire stall;
  wire [15:0] sp_plus1;

  assign tx_take = (tx_state == T_IDLE);
  assign stall = push_valid && !push_ready;
  assign sp_plus1 = i_stack_ptr + 16'h0001;

  ////////////////////////////////////////////////////////////////////////
  // pin input synchroniser, change taken when stages two and three agree
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      sync1 <= 1'b1;
      sync2 <= 1'b1;
      sync3 <= 1'b1;
      rx_line <= 1'b1;
    end else begin
      sync1 <= i_serial_pin;
      sync2 <= sync1;
      sync3 <= sync2;
      if (sync2 == sync3) begin
        rx_line <= sync3;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // receiver: mid-bit sampling, ignores the pin while we drive it
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rx_state <= R_ARM;
      rx_cyc <= 8'h00;
      rx_bit <= 4'h0;
      rx_shift <= 9'h000;
      rx_byte <= 1'b0;
      rx_break <= 1'b0;
      rx_data <= 8'h00;
    end else begin
      rx_byte <= 1'b0;
      rx_break <= 1'b0;
      if (o_serial_pin_oe) begin
        rx_state <= R_ARM;
      end else begin
        case (rx_state)
          R_ARM: begin
            // wait for an idle high line before looking for a start
            if (rx_line) begin
              rx_state <= R_IDLE;
            end
          end
          R_IDLE: begin
            if (!rx_line) begin
              rx_cyc <= HALF_LAST[7:0];
              rx_bit <= 4'h0;
              rx_state <= R_BITS;
            end
          end
          R_BITS: begin
            if (rx_cyc != 8'h00) begin
              rx_cyc <= rx_cyc - 8'h01;
            end else begin
              rx_cyc <= BIT_LAST[7:0];
              rx_bit <= rx_bit + 4'h1;
              if (rx_bit == 4'h0) begin
                if (rx_line) begin
                  rx_state <= R_IDLE; // glitch, not a start
                end
              end else begin
                rx_shift <= {rx_line, rx_shift[8:1]};
                if (rx_bit == 4'h9) begin
                  rx_state <= R_ARM;
                  rx_data <= rx_shift[8:1];
                  if (rx_line) begin
                    rx_byte <= 1'b1;
                  end else if (rx_shift[8:1] == 8'h00) begin
                    rx_break <= 1'b1;
                  end
                end
              end
            end
          end
          default: begin
            rx_state <= R_ARM;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // transmit queue between the engine and the transmitter
  mon_fifo #(
    .WIDTH(`TXQ_WIDTH),
    .DEPTH(`TXQ_DEPTH),
    .AW(`TXQ_AW)
  ) u_txq (
    .i_core_clk(i_core_clk),
    .i_rst_n(i_rst_n),
    .i_in_valid(push_valid),
    .o_in_ready(push_ready),
    .i_in_data(push_data),
    .o_out_valid(txq_valid),
    .i_out_ready(tx_take),
    .o_out_data(txq_data)
  );

  ////////////////////////////////////////////////////////////////////////
  // transmitter: two high bit times, then a frame or a break
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_state <= T_IDLE;
      tx_cyc <= 10'h000;
      tx_bit <= 4'h0;
      tx_shift <= 10'h3ff;
      o_serial_pin_out <= 1'b1;
      o_serial_pin_oe <= 1'b0;
    end else begin
      case (tx_state)
        T_IDLE: begin
          o_serial_pin_oe <= 1'b0;
          o_serial_pin_out <= 1'b1;
          if (txq_valid) begin
            // break is ten zeros, a byte is start, data, stop
            tx_shift <= txq_data[8] ? 10'h000 : {1'b1, txq_data[7:0], 1'b0};
            tx_cyc <= GAP_LAST[9:0];
            o_serial_pin_oe <= 1'b1;
            tx_state <= T_GAP;
          end
        end
        T_GAP: begin
          if (tx_cyc != 10'h000) begin
            tx_cyc <= tx_cyc - 10'h001;
          end else begin
            tx_cyc <= BIT_LAST[9:0];
            tx_bit <= 4'h0;
            o_serial_pin_out <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
            tx_state <= T_FRAME;
          end
        end
        T_FRAME: begin
          if (tx_cyc != 10'h000) begin
            tx_cyc <= tx_cyc - 10'h001;
          end else if (tx_bit == FRAME_LAST[3:0]) begin
            o_serial_pin_out <= 1'b1;
            o_serial_pin_oe <= 1'b0;
            tx_state <= T_IDLE;
          end else begin
            tx_cyc <= BIT_LAST[9:0];
            tx_bit <= tx_bit + 4'h1;
            o_serial_pin_out <= tx_shift[0];
            tx_shift <= {1'b1, tx_shift[9:1]};
          end
        end
        default: begin
          tx_state <= T_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // security bypass survives every reset but power-on
  always @(posedge i_core_clk or negedge i_por_n) begin
    if (!i_por_n) begin
      sec_bypass <= 1'b0;
      o_flash_locked <= 1'b1;
    end else begin
      if (sec_pass) begin
        sec_bypass <= 1'b1;
      end
      o_flash_locked <= !sec_bypass;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // command engine
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= S_START;
      arg_cnt <= 2'h0;
      argv <= 24'h000000;
      cmd <= 8'h00;
      idx <= 16'h0000;
      sec_cnt <= 3'h0;
      sec_ok <= 1'b0;
      sec_pass <= 1'b0;
      sec_code <= 64'h0000000000000000;
      wait_cnt <= 12'h000;
      push_valid <= 1'b0;
      push_data <= 9'h000;
      o_mem_addr <= 16'h0000;
      o_mem_wdata <= 8'h00;
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_stack_entry <= 1'b0;
      o_run <= 1'b0;
      o_vector_page <= `VEC_PAGE_MON;
    end else begin
      o_mem_rd <= 1'b0;
      o_mem_wr <= 1'b0;
      o_stack_entry <= 1'b0;
      o_run <= 1'b0;
      sec_pass <= 1'b0;
      o_vector_page <= `VEC_PAGE_MON;
      if (push_valid && push_ready) begin
        push_valid <= 1'b0;
      end
      if (i_mass_erase) begin
        sec_code <= {`SEC_BYTES{`SEC_BLANK}};
      end
      if (!stall) begin
        case (state)
          S_START: begin
            // cpu stacks its state and index high on entry
            o_stack_entry <= 1'b1;
            sec_code <= i_sec_code;
            sec_cnt <= 3'h0;
            sec_ok <= 1'b1;
            state <= sec_bypass ? S_BRK : S_SEC;
          end
          S_SEC: begin
            if (rx_byte) begin
              push_valid <= 1'b1;
              push_data <= {1'b0, rx_data};
              if (rx_data != code_byte(sec_code, sec_cnt)) begin
                sec_ok <= 1'b0;
              end
              sec_cnt <= sec_cnt + 3'h1;
              if (sec_cnt == SEC_LAST[2:0]) begin
                state <= S_SECCHK;
              end
            end
          end
          S_SECCHK: begin
            if (sec_ok) begin
              sec_pass <= 1'b1;
              o_mem_addr <= `SEC_FLAG_ADDR;
              o_mem_rd <= 1'b1;
              state <= S_FRD;
            end else begin
              state <= S_BRK;
            end
          end
          S_FRD: begin
            state <= S_FWR;
          end
          S_FWR: begin
            // read-modify-write keeps the other flag bits
            o_mem_wdata <= i_mem_rdata | (8'h01 << `SEC_FLAG_BIT);
            o_mem_wr <= 1'b1;
            state <= S_BRK;
          end
          S_BRK: begin
            push_valid <= 1'b1;
            push_data <= 9'h100;
            state <= S_IDLE;
          end
          S_IDLE: begin
            if (rx_break) begin
              state <= S_BRK;
            end else if (rx_byte) begin
              push_valid <= 1'b1;
              push_data <= {1'b0, rx_data};
              cmd <= rx_data;
              wait_cnt <= 12'h000;
              case (rx_data)
                `OP_READ: begin
                  arg_cnt <= 2'h2;
                  state <= S_ARG;
                end
                `OP_WRITE: begin
                  arg_cnt <= 2'h3;
                  state <= S_ARG;
                end
                `OP_INDEXED_WRITE_CMD: begin
                  arg_cnt <= 2'h1;
                  state <= S_ARG;
                end
                `OP_INDEXED_READ_CMD, `OP_STACK_POINTER_READ_CMD, `OP_RUN: begin
                  state <= S_WAIT;
                end
                default: begin
                  state <= S_IDLE;
                end
              endcase
            end
          end
          S_ARG: begin
            if (rx_break) begin
              state <= S_BRK;
            end else if (rx_byte) begin
              push_valid <= 1'b1;
              push_data <= {1'b0, rx_data};
              argv <= {argv[15:0], rx_data};
              arg_cnt <= arg_cnt - 2'h1;
              if (arg_cnt == 2'h1) begin
                state <= S_WAIT;
              end
            end
          end
          S_WAIT: begin
            if (rx_break) begin
              state <= S_BRK;
            end else if (wait_cnt == WAIT_LAST[11:0]) begin
              state <= S_EXEC;
            end else begin
              wait_cnt <= wait_cnt + 12'h001;
            end
          end
          S_EXEC: begin
            state <= S_IDLE;
            case (cmd)
              `OP_READ: begin
                o_mem_addr <= argv[15:0];
                o_mem_rd <= 1'b1;
                idx <= argv[15:0] + 16'h0001;
                state <= S_RWAIT;
              end
              `OP_WRITE: begin
                o_mem_addr <= argv[23:8];
                o_mem_wdata <= argv[7:0];
                o_mem_wr <= 1'b1;
                idx <= argv[23:8] + 16'h0001;
              end
              `OP_INDEXED_READ_CMD: begin
                o_mem_addr <= idx;
                o_mem_rd <= 1'b1;
                idx <= idx + 16'h0001;
                state <= S_RWAIT;
              end
              `OP_INDEXED_WRITE_CMD: begin
                o_mem_addr <= idx;
                o_mem_wdata <= argv[7:0];
                o_mem_wr <= 1'b1;
                idx <= idx + 16'h0001;
              end
              `OP_STACK_POINTER_READ_CMD: begin
                push_valid <= 1'b1;
                push_data <= {1'b0, sp_plus1[15:8]};
                state <= S_SPLO;
              end
              `OP_RUN: begin
                o_run <= 1'b1;
              end
              default: begin
                state <= S_IDLE;
              end
            endcase
          end
          S_RWAIT: begin
            state <= S_RDAT;
          end
          S_RDAT: begin
            // queued behind the echo, so data follows it
            push_valid <= 1'b1;
            if (in_flash(o_mem_addr) && !sec_bypass) begin
              push_data <= {1'b0, `INVALID_DATA};
            end else begin
              push_data <= {1'b0, i_mem_rdata};
            end
            state <= S_IDLE;
          end
          S_SPLO: begin
            push_valid <= 1'b1;
            push_data <= {1'b0, sp_plus1[7:0]};
            state <= S_IDLE;
          end
          default: begin
            state <= S_START;
          end
        endcase
      end
    end
  end
endmodule

/* bench/monitor_serial_port_props.sv */
// assertion checker for the monitor serial port pins, entry pulse, vector page, flash lock and memory read strobe
`timescale 1ns/1ps
`include "mon_consts.vh"
module monitor_serial_port_props (
  input wire i_core_clk,
  input wire i_rst_n,
  input wire i_por_n,
  input wire i_serial_pin,
  input wire o_serial_pin_out,
  input wire o_serial_pin_oe,
  input wire [15:0] o_mem_addr,
  input wire o_mem_rd,
  input wire o_stack_entry,
  input wire o_flash_locked,
  input wire [7:0] o_vector_page
);
  localparam int GAP = 512;
  localparam int LAST = 3071;
  localparam int RD_MIN = 5248;
  localparam int RD_MAX = 5290;
  localparam int FRAME_END = 2400;
  logic [12:0] tx_cnt;
  logic [12:0] rx_age;
  logic pin_d;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_n);
  //////////////////////////////////////////////////////////////
  // cycles since drive enable rose, and since the host start edge
  always @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      tx_cnt <= 13'h0000;
      rx_age <= 13'h1fff;
      pin_d <= 1'b1;
    end else begin
      tx_cnt <= o_serial_pin_oe ? tx_cnt + 13'h0001 : 13'h0000;
      pin_d <= i_serial_pin;
      // falling edges inside a host frame do not restart the count
      if (!o_serial_pin_oe && pin_d && !i_serial_pin
          && rx_age > FRAME_END) begin
        rx_age <= 13'h0000;
      end else if (rx_age != 13'h1fff) begin
        rx_age <= rx_age + 13'h0001;
      end
    end
  end
  //////////////////////////////////////////////////////////////
  a_gap_high: assert property (
    o_serial_pin_oe && tx_cnt < GAP |-> o_serial_pin_out)
    else $error("pin not high during the two bit gap");
  a_start_low: assert property (
    o_serial_pin_oe && tx_cnt == GAP |-> !o_serial_pin_out)
    else $error("no start bit after the gap");
  a_cell_steady: assert property (
    o_serial_pin_oe && tx_cnt > GAP && tx_cnt[7:0] != 8'h00
    |-> $stable(o_serial_pin_out))
    else $error("pin changed inside a bit cell");
  a_frame_span: assert property (
    o_serial_pin_oe && tx_cnt < LAST |=> o_serial_pin_oe)
    else $error("drive dropped before ten cells ended");
  a_entry_pulse: assert property (
    $rose(i_rst_n) |-> ##[0:2] o_stack_entry)
    else $error("no stack entry pulse after reset");
  a_vec_page: assert property (
    o_vector_page == `VEC_PAGE_MON)
    else $error("vector page not the monitor page");
  a_lock_por: assert property (
    disable iff (1'b0) !i_por_n |-> o_flash_locked)
    else $error("flash not locked during power-on reset");
  a_lock_keep: assert property (
    disable iff (!i_por_n) !o_flash_locked |=> !o_flash_locked)
    else $error("bypass lost without power-on reset");
  a_read_wait: assert property (
    o_mem_rd && o_mem_addr != `SEC_FLAG_ADDR
    |-> rx_age >= RD_MIN && rx_age <= RD_MAX)
    else $error("memory read not eleven bits after last byte");
endmodule
bind monitor_serial_port monitor_serial_port_props u_props (
  .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
  .i_serial_pin(i_serial_pin), .o_serial_pin_out(o_serial_pin_out),
  .o_serial_pin_oe(o_serial_pin_oe), .o_mem_addr(o_mem_addr),
  .o_mem_rd(o_mem_rd), .o_stack_entry(o_stack_entry),
  .o_flash_locked(o_flash_locked), .o_vector_page(o_vector_page));

/* bench/host_model.sv */
// host side model: open-drain sender and sampler on the serial line
`timescale 1ns/1ps
module host_model (
  input wire i_core_clk,
  input wire i_line,
  output reg o_drive_low
);
  initial o_drive_low = 1'b0;
  //////////////////////////////////////////////////////////////
  // one bit cell of 256 bus cycles, released means pulled high
  task automatic bit_out(input logic v);
    o_drive_low <= !v;
    repeat (256) @(negedge i_core_clk);
  endtask
  // start, eight data lsb first, stop
  task automatic send(input logic [7:0] b);
    integer i;
    bit_out(1'b0);
    for (i = 0; i < 8; i = i + 1) begin
      bit_out(b[i]);
    end
    bit_out(1'b1);
  endtask
  // frame as {stop, data}; a break reads back as all zeros
  task automatic recv(output logic [8:0] f, output logic ok);
    integer n;
    integer i;
    n = 0;
    while (i_line !== 1'b0 && n < 20000) begin
      @(negedge i_core_clk);
      n = n + 1;
    end
    ok = (n < 20000);
    repeat (128) @(negedge i_core_clk);
    for (i = 0; i < 9; i = i + 1) begin
      repeat (256) @(negedge i_core_clk);
      f[i] = i_line;
    end
    repeat (384) @(negedge i_core_clk);
  endtask
endmodule

/* bench/monitor_serial_debug_port_tb_top.sv */
// self-checking bench for the monitor serial port
`timescale 1ns/1ps
`include "mon_consts.vh"
module monitor_serial_debug_port_tb_top;
  localparam logic [63:0] CODE = 64'h8877_6655_4433_2211; // arbitrary
  reg i_core_clk = 1'b0;
  reg i_rst_n = 1'b1;
  reg i_por_n = 1'b1;
  reg [7:0] i_mem_rdata = 8'h00;
  reg [15:0] rd_addr = 16'h0000;
  reg [15:0] wr_addr = 16'h0000;
  reg [7:0] wr_data = 8'h00;
  wire entry;
  wire run;
  wire line;
  wire pin_out;
  wire pin_oe;
  wire host_low;
  wire [15:0] mem_addr;
  wire [7:0] mem_wdata;
  wire mem_rd;
  wire mem_wr;
  wire locked;
  integer err_total = 0;
  integer n_checks = 0;
  integer n_entry = 0;
  integer n_run = 0;
  //////////////////////////////////////////////////////////////
  // clock, pulled-up line, memory answering with inverted address
  always #2 i_core_clk = ~i_core_clk;
  assign line = pin_oe ? (host_low ? 1'bx : pin_out) : !host_low;
  always @(negedge i_core_clk) i_mem_rdata <= ~mem_addr[7:0];
  always @(posedge i_core_clk) begin
    if (mem_rd) rd_addr <= mem_addr;
    if (mem_wr) wr_addr <= mem_addr;
    if (mem_wr) wr_data <= mem_wdata;
    if (entry) n_entry <= n_entry + 1;
    if (run) n_run <= n_run + 1;
  end
  //////////////////////////////////////////////////////////////
  monitor_serial_port u_dut (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_por_n(i_por_n),
    .i_serial_pin(line), .o_serial_pin_out(pin_out),
    .o_serial_pin_oe(pin_oe), .i_sec_code(CODE), .i_mass_erase(1'b0),
    .i_stack_ptr(16'h12ff), .i_mem_rdata(i_mem_rdata),
    .o_mem_addr(mem_addr), .o_mem_wdata(mem_wdata), .o_mem_rd(mem_rd),
    .o_mem_wr(mem_wr), .o_stack_entry(entry), .o_run(run),
    .o_flash_locked(locked), .o_vector_page());
  host_model u_host (.i_core_clk(i_core_clk), .i_line(line),
    .o_drive_low(host_low));
  //////////////////////////////////////////////////////////////
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_checks = n_checks + 1;
    if (seen !== exp) begin
      err_total = err_total + 1;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic get(output logic [8:0] f);
    logic ok;
    u_host.recv(f, ok);
    if (ok !== 1'b1) begin
      err_total = err_total + 1;
      $display("[FAIL] frame expected start seen idle");
      final_report;
    end
  endtask
  task automatic echo(input logic [7:0] b);
    logic [8:0] f;
    u_host.send(b);
    get(f);
    check("echo", {7'h00, f}, {8'h01, b});
  endtask
  //////////////////////////////////////////////////////////////
  // indexed read steps on from the last read address, queued after echo
  task automatic t_index;
    logic [8:0] f;
    echo(`OP_INDEXED_READ_CMD);
    get(f);
    check("indexed_read_cmd data", {7'h00, f}, 16'h01ee);
    check("indexed_read_cmd addr", rd_addr, 16'hc011);
    check("run idle", n_run[15:0], 16'h0000);
    $display("test indexed read done");
  endtask
  task automatic t_security;
    logic [8:0] f;
    integer i;
    for (i = 0; i < 8; i = i + 1) begin
      check("locked", {15'h0000, locked}, 16'h0001);
      echo(CODE[8*i +: 8]);
    end
    get(f);
    check("ready break", {7'h00, f}, 16'h0000);
    check("flag addr", wr_addr, 16'h0040);
    check("flag data", {8'h00, wr_data}, 16'h00ff);
    check("unlocked", {15'h0000, locked}, 16'h0000);
    $display("test security done");
  endtask
  task automatic t_warm;
    logic [8:0] f;
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_rst_n = 1'b1;
    get(f);
    check("warm break", {7'h00, f}, 16'h0000);
    check("still open", {15'h0000, locked}, 16'h0000);
    check("entry pulses", n_entry[15:0], 16'h0002);
    $display("test warm reset done");
  endtask
  task automatic t_read;
    logic [8:0] f;
    echo(`OP_READ);
    echo(8'hc0);
    echo(8'h10);
    get(f);
    check("read data", {7'h00, f}, 16'h01ef);
    check("read addr", rd_addr, 16'hc010);
    $display("test read done");
  endtask
  task automatic t_stack_pointer_read_cmd;
    logic [8:0] f;
    echo(`OP_STACK_POINTER_READ_CMD);
    get(f);
    check("sp high", {7'h00, f}, 16'h0113);
    get(f);
    check("sp low", {7'h00, f}, 16'h0100);
    $display("test stack pointer done");
  endtask
  //////////////////////////////////////////////////////////////
  // power-on reset, then the scenarios in order
  initial begin
    #1;
    i_por_n = 1'b0;
    i_rst_n = 1'b0;
    repeat (3) @(negedge i_core_clk);
    i_por_n = 1'b1;
    i_rst_n = 1'b1;
    t_security;
    t_warm;
    t_read;
    t_index;
    t_stack_pointer_read_cmd;
    final_report;
  end
endmodule
